/* rtl/l1_entry_timer.sv */
`timescale 1ns/1ns
module l1_entry_timer #(
  parameter int CYC0 = 6400,
  parameter int CYC1 = 25600,
  parameter int CYC2 = 100000,
  parameter int CYC3 = 400000
) (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       in_l0s,
  input  wire logic [1:0] sel,
  output logic            l1_entry_req
);

  logic [19:0] cnt_q;
  logic [19:0] cnt_d;
  logic        done_q;
  logic        done_d;
  logic [19:0] target;
  logic        fire;

  always_comb
  begin
    case (sel)
      2'b00:   target = 20'(CYC0);
      2'b01:   target = 20'(CYC1);
      2'b10:   target = 20'(CYC2);
      default: target = 20'(CYC3);
    endcase
  end

  assign fire = in_l0s && !done_q && (cnt_q == target - 20'h0_0001);

  always_comb
  begin
    cnt_d  = cnt_q;
    done_d = done_q;
    if (!in_l0s)
    begin
      cnt_d  = 20'h0_0000;
      done_d = 1'b0;
    end
    else if (fire)
    begin
      done_d = 1'b1;
    end
    else if (!done_q)
    begin
      cnt_d = cnt_q + 20'h0_0001;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cnt_q        <= 20'h0_0000;
      done_q       <= 1'b0;
      l1_entry_req <= 1'b0;
    end
    else
    begin
      cnt_q        <= cnt_d;
      done_q       <= done_d;
      l1_entry_req <= fire;
    end
  end

  chk_l1_delay_exact: assert property (@(posedge clk_sys) disable iff (srst)
    l1_entry_req |-> $past(in_l0s) && $past(cnt_q) == target - 20'h0_0001)
    else $error("l1 entry request at wrong count");

endmodule

/* rtl/link_cfg_defs.svh */
`ifndef LINK_CFG_DEFS_SVH
`define LINK_CFG_DEFS_SVH

// register indices; byte address is four times the index
`define LCW_WORD_IDX 8'h1b
`define LCW_STAT_IDX 8'h1c

// configuration word reset value and reserved positions
`define LCW_WORD_RST 16'h8403
`define LCW_RSV_MASK 16'h47c0
`define LCW_RSV_VAL  16'h0400

// field positions within the configuration word
`define LCW_B_RXOVR  15
`define LCW_B_LDINH  13
`define LCW_B_LREVD  12
`define LCW_B_GOODR  11
`define LCW_B_L2BLK  5
`define LCW_B_SKPD   4
`define LCW_B_CGATE  3
`define LCW_B_EIMSK  2
`define LCW_B_L1SEL  1

// status register bit positions
`define LCW_S_READY  0
`define LCW_S_LOCK   1
`define LCW_S_NVMOK  2
`define LCW_S_RSVBAD 3
`define LCW_S_PARTN  4

// timing
`define LCW_CLK_MHZ  100
`define LCW_L1_T0_US 64
`define LCW_L1_T1_US 256
`define LCW_L1_T2_US 1000
`define LCW_L1_T3_US 4000

`endif

/* rtl/link_cfg_loader.sv */
// Notes on behaviour
// - presence override forces partner detected
// - link loss resets core unless inhibited; code ignores link loss until cfg_ready is set
// - lane reversal allowed only when bit clear
// - forced good recovery drives recovery to link-up
// - extended fast-training flag set in TS1/TS2
// - L2 entry blocked when bit set
// - skip insertion stops when bit set
// - L0s clock gating only when enabled
// - idle mask skips illegal idle sequence check
// - masked: either idle form alone is valid
// - L1 entry delay 64us/256us/1ms/4ms
// - settings come from the single config word
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "link_cfg_defs.svh"
module link_cfg_loader #(
  parameter int L1_CYC0 = `LCW_L1_T0_US * `LCW_CLK_MHZ,
  parameter int L1_CYC1 = `LCW_L1_T1_US * `LCW_CLK_MHZ,
  parameter int L1_CYC2 = `LCW_L1_T2_US * `LCW_CLK_MHZ,
  parameter int L1_CYC3 = `LCW_L1_T3_US * `LCW_CLK_MHZ
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        nvm_load_done,
  input  wire logic        nvm_word_valid,
  input  wire logic [15:0] nvm_word,
  input  wire logic        training_start,
  input  wire logic        rx_detect_seen,
  input  wire logic        link_down,
  input  wire logic        in_l0s,
  input  wire logic        eidle_os_seen,
  input  wire logic        eidle_cm_seen,
  output logic             cfg_ready,
  output logic             partner_detected,
  output logic             core_reset_req,
  output logic             lane_reversal_allow,
  output logic             recovery_force_good,
  output logic             long_fast_training_request,
  output logic             l2_entry_allow,
  output logic             skp_insert_en,
  output logic             standby_clock_gating_on,
  output logic             eidle_valid,
  output logic             eidle_illegal,
  output logic             l1_entry_req
);

  localparam logic [7:0] WORD_ADDR = 8'(`LCW_WORD_IDX * 4);
  localparam logic [7:0] STAT_ADDR = 8'(`LCW_STAT_IDX * 4);

  link_cfg_pkg::load_state_t state_q;
  link_cfg_pkg::load_state_t state_d;
  link_cfg_pkg::cfg_fields_t cfg;
  logic [15:0]               word_q;
  logic [15:0]               word_d;
  logic                      lock_q;
  logic                      lock_d;
  logic                      nvm_ok_q;
  logic                      nvm_ok_d;
  logic                      rst_req_q;
  logic                      rst_req_d;
  logic [31:0]               rdata_q;
  logic [31:0]               rdata_d;
  logic                      err_q;
  logic                      err_d;
  logic                      setup;
  logic                      access;
  logic                      hit_word;
  logic                      hit_stat;
  logic                      wr_ok;
  logic                      rsv_bad;
  logic [15:0]               status;

  // decoded view of the active word
  always_comb
  begin
    cfg.rx_override      = word_q[`LCW_B_RXOVR];
    cfg.linkdown_inhibit = word_q[`LCW_B_LDINH];
    cfg.lane_rev_off     = word_q[`LCW_B_LREVD];
    cfg.good_recovery    = word_q[`LCW_B_GOODR];
    cfg.l2_block         = word_q[`LCW_B_L2BLK];
    cfg.skp_off          = word_q[`LCW_B_SKPD];
    cfg.clock_gate       = word_q[`LCW_B_CGATE];
    cfg.eidle_mask       = word_q[`LCW_B_EIMSK];
    cfg.l1_sel           = word_q[`LCW_B_L1SEL -: 2];
  end

  // apb decode; read data captured in setup, zero-wait access
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hit_word = (paddr == WORD_ADDR);
  assign hit_stat = (paddr == STAT_ADDR);
  assign wr_ok    = access && pwrite && hit_word && cfg_ready && !lock_q;
  assign pready   = access;
  assign pslverr  = access && err_q;
  assign prdata   = rdata_q;

  assign rsv_bad = ((word_q & `LCW_RSV_MASK) != `LCW_RSV_VAL);

  always_comb
  begin
    status                 = 16'h0000;
    status[`LCW_S_READY]   = cfg_ready;
    status[`LCW_S_LOCK]    = lock_q;
    status[`LCW_S_NVMOK]   = nvm_ok_q;
    status[`LCW_S_RSVBAD]  = rsv_bad;
    status[`LCW_S_PARTN]   = partner_detected;
  end

  always_comb
  begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup)
    begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      if (hit_word)
      begin
        rdata_d = {16'h0000, word_q};
        err_d   = pwrite && (!cfg_ready || lock_q);
      end
      else if (hit_stat)
      begin
        rdata_d = {16'h0000, status};
        err_d   = pwrite;
      end
      else
      begin
        err_d = 1'b1;
      end
    end
  end

  // load sequencer
  always_comb
  begin
    state_d  = state_q;
    word_d   = word_q;
    nvm_ok_d = nvm_ok_q;
    lock_d   = lock_q;
    case (state_q)
      link_cfg_pkg::ST_WAIT_LOAD:
      begin
        if (nvm_load_done)
        begin
          state_d  = link_cfg_pkg::ST_READY;
          nvm_ok_d = nvm_word_valid;
          word_d   = nvm_word_valid ? nvm_word : `LCW_WORD_RST;
        end
      end
      link_cfg_pkg::ST_READY:
      begin
        if (training_start)
        begin
          lock_d = 1'b1;
        end
        if (wr_ok)
        begin
          word_d = pwdata[15:0];
        end
      end
      default:
      begin
        state_d = link_cfg_pkg::ST_WAIT_LOAD;
      end
    endcase
  end

  assign cfg_ready = (state_q == link_cfg_pkg::ST_READY);

  // core reset request on link loss
  assign rst_req_d = link_down && cfg_ready && !cfg.linkdown_inhibit;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_q   <= link_cfg_pkg::ST_WAIT_LOAD;
      word_q    <= `LCW_WORD_RST;
      nvm_ok_q  <= 1'b0;
      lock_q    <= 1'b0;
      rst_req_q <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      err_q     <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      word_q    <= word_d;
      nvm_ok_q  <= nvm_ok_d;
      lock_q    <= lock_d;
      rst_req_q <= rst_req_d;
      rdata_q   <= rdata_d;
      err_q     <= err_d;
    end
  end

  assign core_reset_req             = rst_req_q;
  assign partner_detected           = cfg.rx_override || rx_detect_seen;
  assign lane_reversal_allow        = !cfg.lane_rev_off;
  assign recovery_force_good        = cfg.good_recovery;
  // partner answers with the long fast-training run
  assign long_fast_training_request = cfg.good_recovery;
  assign l2_entry_allow             = !cfg.l2_block;
  assign skp_insert_en              = !cfg.skp_off;
  assign standby_clock_gating_on    = cfg.clock_gate && in_l0s;

  // idle sequence check; masked mode takes either form
  assign eidle_valid   = cfg.eidle_mask ? (eidle_os_seen || eidle_cm_seen)
                                        : (eidle_os_seen && eidle_cm_seen);
  assign eidle_illegal = !cfg.eidle_mask && (eidle_os_seen != eidle_cm_seen);

  l1_entry_timer #(
    .CYC0 (L1_CYC0),
    .CYC1 (L1_CYC1),
    .CYC2 (L1_CYC2),
    .CYC3 (L1_CYC3)
  ) u_l1_timer (
    .clk_sys      (clk_sys),
    .srst         (srst),
    .in_l0s       (in_l0s),
    .sel          (cfg.l1_sel),
    .l1_entry_req (l1_entry_req)
  );

  chk_rx_override: assert property (@(posedge clk_sys) disable iff (srst)
    word_q[15] |-> partner_detected)
    else $error("override set but partner not detected");

  chk_linkdown_reset: assert property (@(posedge clk_sys) disable iff (srst)
    link_down && cfg_ready |=> core_reset_req == !$past(word_q[13]))
    else $error("core reset on link loss wrong");

  chk_lane_reversal: assert property (@(posedge clk_sys) disable iff (srst)
    lane_reversal_allow != word_q[`LCW_B_LREVD])
    else $error("lane reversal still allowed");

  chk_good_recovery: assert property (@(posedge clk_sys) disable iff (srst)
    recovery_force_good == word_q[11] && long_fast_training_request == word_q[11])
    else $error("recovery or fast-training flag mismatch");

  chk_l2_skip: assert property (@(posedge clk_sys) disable iff (srst)
    (l2_entry_allow != word_q[5]) && (skp_insert_en != word_q[4]))
    else $error("l2 or skip control mismatch");

  chk_clock_gate: assert property (@(posedge clk_sys) disable iff (srst)
    standby_clock_gating_on == (in_l0s && word_q[`LCW_B_CGATE]))
    else $error("clock gating outside enabled l0s");

  chk_eidle_masked: assert property (@(posedge clk_sys) disable iff (srst)
    word_q[2] |-> !eidle_illegal)
    else $error("illegal idle flagged while masked");

  chk_eidle_either: assert property (@(posedge clk_sys) disable iff (srst)
    word_q[2] && (eidle_os_seen != eidle_cm_seen) |-> eidle_valid)
    else $error("single idle form refused while masked");

  chk_load_word: assert property (@(posedge clk_sys) disable iff (srst)
    !cfg_ready && nvm_load_done && nvm_word_valid |=> cfg_ready && word_q == $past(nvm_word))
    else $error("nonvolatile word not applied");

  chk_load_default: assert property (@(posedge clk_sys) disable iff (srst)
    !cfg_ready && nvm_load_done && !nvm_word_valid |=> word_q == `LCW_WORD_RST)
    else $error("defaults not applied");

  chk_locked_stable: assert property (@(posedge clk_sys) disable iff (srst)
    lock_q |=> $stable(word_q) && lock_q)
    else $error("settings changed after training start");

  chk_apb_zero_wait: assert property (@(posedge clk_sys) disable iff (srst)
    psel && penable |-> pready)
    else $error("access phase without ready");

  chk_unmapped_error: assert property (@(posedge clk_sys) disable iff (srst)
    access && !hit_word && !hit_stat |-> pslverr)
    else $error("unmapped access not flagged");

  chk_locked_write_refused: assert property (@(posedge clk_sys) disable iff (srst)
    access && pwrite && hit_word && lock_q |=> $stable(word_q))
    else $error("word written while locked");

  chk_ready_sticky: assert property (@(posedge clk_sys) disable iff (srst)
    cfg_ready |=> cfg_ready)
    else $error("ready dropped without reset");

  chk_reset_inhibited: assert property (@(posedge clk_sys) disable iff (srst)
    link_down && word_q[`LCW_B_LDINH] |=> !core_reset_req)
    else $error("core reset despite inhibit");

  chk_reset_before_load: assert property (@(posedge clk_sys) disable iff (srst)
    !cfg_ready |=> !core_reset_req)
    else $error("core reset before word loaded");

  chk_l1_single_pulse: assert property (@(posedge clk_sys) disable iff (srst)
    l1_entry_req |=> !l1_entry_req)
    else $error("l1 entry request longer than one cycle");

endmodule

/* rtl/link_cfg_pkg.sv */
package link_cfg_pkg;

  typedef enum logic [1:0]
  {
    ST_WAIT_LOAD = 2'b01,
    ST_READY     = 2'b10
  } load_state_t;

  typedef struct packed
  {
    logic       rx_override;
    logic       linkdown_inhibit;
    logic       lane_rev_off;
    logic       good_recovery;
    logic       l2_block;
    logic       skp_off;
    logic       clock_gate;
    logic       eidle_mask;
    logic [1:0] l1_sel;
  } cfg_fields_t;

endpackage

/* verification/tb_pcie_link_control_config_word.sv */
`timescale 1ns/1ns
module tb_pcie_link_control_config_word;
  logic        clk_sys = 0;
  logic        srst = 1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, nvm_load_done = 0, nvm_word_valid = 0;
  logic [15:0] nvm_word = 16'h0000;
  logic        training_start, rx_detect_seen, link_down, in_l0s;
  logic        eidle_os_seen, eidle_cm_seen, cfg_ready, partner_detected;
  logic        core_reset_req, lane_reversal_allow, recovery_force_good;
  logic        long_fast_training_request, l2_entry_allow, skp_insert_en;
  logic        standby_clock_gating_on, eidle_valid, eidle_illegal, l1_entry_req;
  int          err_total = 0, total_checks = 0;

  link_cfg_loader #(.L1_CYC0(4), .L1_CYC1(8), .L1_CYC2(12), .L1_CYC3(16)) uut (
    .clk_sys, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .nvm_load_done, .nvm_word_valid, .nvm_word,
    .training_start, .rx_detect_seen, .link_down, .in_l0s, .eidle_os_seen,
    .eidle_cm_seen, .cfg_ready, .partner_detected, .core_reset_req,
    .lane_reversal_allow, .recovery_force_good, .long_fast_training_request,
    .l2_entry_allow, .skp_insert_en, .standby_clock_gating_on, .eidle_valid,
    .eidle_illegal, .l1_entry_req);

  upstream_port_model up (
    .clk_sys, .long_fast_training_request, .training_start, .rx_detect_seen,
    .link_down, .in_l0s, .eidle_os_seen, .eidle_cm_seen);

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] er, input logic ee);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    if (!w)
      chk(prdata, er, "read data");
    chk(pslverr, ee, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task do_reset();
    srst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
  endtask

  task load(input logic v, input logic [15:0] w);
    @(posedge clk_sys);
    nvm_load_done <= 1'b1;
    nvm_word_valid <= v;
    nvm_word <= w;
    @(posedge clk_sys);
    nvm_load_done <= 1'b0;
    @(negedge clk_sys);
    chk(cfg_ready, 1, "ready after load");
  endtask

  task link_checks(input logic [15:0] w, input int n);
    int c;
    @(negedge clk_sys);
    chk(partner_detected, w[15] | rx_detect_seen, "presence");
    chk(up.fts_count, w[11] ? 4096 : 255, "fts burst length");
    chk(lane_reversal_allow, !w[12], "lane reversal");
    chk(recovery_force_good, w[11], "good recovery");
    chk(long_fast_training_request, w[11], "long fts");
    chk(l2_entry_allow, !w[5], "l2 entry");
    chk(skp_insert_en, !w[4], "skip insert");
    chk(standby_clock_gating_on, 0, "gating outside l0s");
    up.detect(1'b1);
    @(negedge clk_sys);
    chk(partner_detected, 1, "presence by detection");
    up.detect(1'b0);
    @(negedge clk_sys);
    chk(partner_detected, w[15], "presence by override");
    for (int k = 0; k < 4; k++)
    begin
      up.idle(k[1], k[0]);
      @(negedge clk_sys);
      chk(eidle_valid, w[2] ? k[1] | k[0] : k[1] & k[0], "idle valid");
      chk(eidle_illegal, !w[2] & (k[1] ^ k[0]), "idle illegal");
    end
    up.drop_link();
    @(negedge clk_sys);
    chk(core_reset_req, !w[13], "core reset");
    @(negedge clk_sys);
    chk(core_reset_req, 0, "core reset pulse");
    up.set_l0s(1'b1);
    c = 0;
    @(negedge clk_sys);
    while (l1_entry_req !== 1'b1 && c < 100)
    begin
      @(negedge clk_sys);
      c++;
    end
    chk(c, n, "l1 delay");
    chk(standby_clock_gating_on, w[3], "gating in l0s");
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk(l1_entry_req, 0, "l1 pulse");
    up.set_l0s(1'b0);
    $display("test done word %h", w);
  endtask

  task lock_checks();
    apb(1'b0, 8'h70, 0, 32'h0000_0005, 1'b0);
    apb(1'b0, 8'h40, 0, 0, 1'b1);
    apb(1'b1, 8'h70, 32'h0000_001f, 0, 1'b1);
    up.start_training();
    apb(1'b1, 8'h6c, 32'h0000_8403, 0, 1'b1);
    apb(1'b0, 8'h6c, 0, 32'h0000_0401, 1'b0);
    apb(1'b0, 8'h70, 0, 32'h0000_0007, 1'b0);
    $display("test done lock");
  endtask

  task wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end

  initial
  begin
    do_reset();
    apb(1'b1, 8'h6c, 32'h0000_3c3c, 0, 1'b1);
    apb(1'b0, 8'h6c, 0, 32'h0000_8403, 1'b0);
    load(1'b0, 16'h3c3c);
    link_checks(16'h8403, 16);
    do_reset();
    load(1'b1, 16'h3c3c);
    link_checks(16'h3c3c, 4);
    apb(1'b1, 8'h6c, 32'hffff_0401, 0, 1'b0);
    apb(1'b0, 8'h6c, 0, 32'h0000_0401, 1'b0);
    link_checks(16'h0401, 8);
    lock_checks();
    wrap_up();
  end
endmodule

/* verification/upstream_port_model.sv */
`timescale 1ns/1ns
module upstream_port_model (
  input  wire logic clk_sys,
  input  wire logic long_fast_training_request,
  output logic      training_start,
  output logic      rx_detect_seen,
  output logic      link_down,
  output logic      in_l0s,
  output logic      eidle_os_seen,
  output logic      eidle_cm_seen
);
  int fts_count;
  initial
  begin
    {training_start, rx_detect_seen, link_down} = 3'b000;
    {in_l0s, eidle_os_seen, eidle_cm_seen} = 3'b000;
  end
  // fast-training burst length sent on standby exit
  assign fts_count = long_fast_training_request ? 4096 : 255;
  task set_l0s(input logic v);
    @(posedge clk_sys);
    in_l0s <= v;
  endtask
  task detect(input logic v);
    @(posedge clk_sys);
    rx_detect_seen <= v;
  endtask
  task drop_link();
    @(posedge clk_sys);
    link_down <= 1'b1;
    @(posedge clk_sys);
    link_down <= 1'b0;
  endtask
  task idle(input logic os, input logic cm);
    @(posedge clk_sys);
    eidle_os_seen <= os;
    eidle_cm_seen <= cm;
  endtask
  task start_training();
    @(posedge clk_sys);
    training_start <= 1'b1;
  endtask
endmodule
